// ==== pkg/fdcp_defines.svh ====
`ifndef FDCP_DEFINES_SVH
`define FDCP_DEFINES_SVH

// ============================================================
// Register slot indices (two index bits).
`define FDCP_IDX_STATUS 2'h0
`define FDCP_IDX_TRACK 2'h1
`define FDCP_IDX_SECTOR 2'h2
`define FDCP_IDX_DATA 2'h3

// ============================================================
// Operation codes held in the upper nibble of a command byte.
`define FDCP_OP_RESTORE 4'h0
`define FDCP_OP_SEEK 4'h1
`define FDCP_OP_STEP_IN 4'h5
`define FDCP_OP_STEP_OUT 4'h7
`define FDCP_OP_READ 4'h8
`define FDCP_OP_WRITE 4'hA
`define FDCP_OP_FORCE 4'hD

// Command flag bit positions.
`define FDCP_CMD_MOTOR_BIT 3
`define FDCP_CMD_PRECOMP_BIT 1

// Status bit positions.
`define FDCP_ST_BUSY_BIT 0
`define FDCP_ST_XREQ_BIT 1
`define FDCP_ST_TRK0_BIT 2
`define FDCP_ST_MOTOR_BIT 7

// Reset values.
`define FDCP_RST_BYTE 8'h00

// ============================================================
// Timing, in Hz, ns, bit/s and cycles of the 50 MHz system clock.
`define FDCP_CLK_HZ 50000000
`define FDCP_CLK_NS 20
`define FDCP_FM_BPS 125000
`define FDCP_MFM_BPS 250000
`define FDCP_FM_CELL_CYC (`FDCP_CLK_HZ / `FDCP_FM_BPS)
`define FDCP_MFM_CELL_CYC (`FDCP_CLK_HZ / `FDCP_MFM_BPS)
`define FDCP_PRECOMP_NS 125
`define FDCP_PRECOMP_CYC (`FDCP_PRECOMP_NS / `FDCP_CLK_NS)
`define FDCP_STEP_PULSE_NS 4000
`define FDCP_STEP_PULSE_CYC \
  ((`FDCP_STEP_PULSE_NS + `FDCP_CLK_NS - 1) / `FDCP_CLK_NS)
`define FDCP_STEP_RATE_CYC 300000
`define FDCP_SPINUP_CYC 60000000
`define FDCP_SECT_BYTES 128

`endif

// ==== pkg/fdcp_pkg.sv ====
// ============================================================
// Shared types of the floppy host and drive port.
package fdcp_pkg;

  // Sequencer states of the port.
  typedef enum logic [2:0] {
    st_idle,
    st_spin,
    st_step,
    st_rx,
    st_tx
  } fdcp_state_t;

endpackage

// ==== design/fdcp_step_gen.sv ====
`timescale 1ns/1ps
`include "fdcp_defines.svh"

// ============================================================
// Head stepper: one pulse per start, then a settle gap.
module fdcp_step_gen import fdcp_pkg::*; #(
  parameter int unsigned STEP_RATE_CYC = `FDCP_STEP_RATE_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  // Request side.
  input wire logic start,
  input wire logic dir_in,
  output logic busy,
  output logic done,
  // Drive side.
  output logic step_pulse,
  output logic head_direction
);

  logic [31:0] cnt_ff; // Cycles since the step began.
  logic busy_ff; // A step and its gap are in progress.
  logic dir_ff; // Latched direction, high means inward.
  logic pulse_ff; // Registered step output.

  wire last_w = busy_ff && (cnt_ff == 32'(STEP_RATE_CYC - 1));

  assign busy = busy_ff;
  assign done = last_w;
  assign step_pulse = pulse_ff;
  assign head_direction = dir_ff;

  // Counter and pulse; the gap keeps the drive's step rate.
  // one pulse per step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0000_0000;
      busy_ff <= 1'b0;
      pulse_ff <= 1'b0;
    end else if (clr || last_w) begin
      cnt_ff <= 32'h0000_0000;
      busy_ff <= 1'b0;
      pulse_ff <= 1'b0;
    end else if (start && !busy_ff) begin
      busy_ff <= 1'b1;
      pulse_ff <= 1'b1;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
      pulse_ff <= (cnt_ff < 32'(`FDCP_STEP_PULSE_CYC - 1));
    end
  end

  // Direction is latched on the same edge that starts the pulse and held through it.
  // direction level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_ff <= 1'b0;
    end else if (start && !busy_ff) begin
      dir_ff <= dir_in;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  step_width_a: assert property (
    $rose(step_pulse) && !clr |=> step_pulse[*8])
    else $error("step pulse shorter than its minimum width");
  dir_hold_a: assert property (
    step_pulse && !clr |=> $stable(head_direction))
    else $error("direction changed during a step pulse");

endmodule

// ==== design/fdcp_port.sv ====
`timescale 1ns/1ps
`include "fdcp_defines.svh"

// Function
// - FM 125 kbit/s, MFM 250 kbit/s cells
// - Optional 125 ns early/late write shift; the code shifts by 6 cycles (120 ns)
// - Motor on before operating the drive; a command without the motor bit runs even while the motor is off
// - Transfers only while select is low
// - Read/write line sets transfer direction
// - Index decodes status/command, track, sector, data
// - Eight-line bus direction follows select, read/write
// - Master reset clears state and status
// - One step pulse per head movement
// - Direction high inward, low outward
// - Recover data from raw read pulses
// - Density input low selects MFM
// - Completion interrupt, cleared by status read
// - Transfer request when data full/empty
// - Track count follows each step
module fdcp_port import fdcp_pkg::*; #(
  parameter int unsigned STEP_RATE_CYC = `FDCP_STEP_RATE_CYC,
  parameter int unsigned SPINUP_CYC = `FDCP_SPINUP_CYC
) (
  // Clock and resets.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_reset_n,
  // Host register port.
  input wire logic cs_n,
  input wire logic rw,
  input wire logic [1:0] reg_index_bits,
  input wire logic [7:0] host_data_lines_i,
  output logic [7:0] host_data_lines_o,
  output logic host_data_lines_oe,
  output logic command_done_irq,
  output logic byte_transfer_request,
  // Drive side.
  input wire logic raw_read_n,
  input wire logic density_select_n,
  output logic step_pulse,
  output logic head_direction,
  output logic spindle_drive_enable,
  output logic write_pulse
);

  // ============================================================
  // Decoding helpers.
  function automatic logic at_idx(input logic [1:0] idx,
                                  input logic [1:0] want);
    at_idx = (idx == want);
  endfunction

  // ============================================================
  // State.
  fdcp_state_t state_ff, nxt_state;
  logic [7:0] track_ff, sector_ff, data_ff, cmd_ff, shift_ff;
  logic [7:0] dout_ff; // Registered bus output byte.
  logic [7:0] bytes_ff; // Bytes moved in the current transfer.
  logic [15:0] cell_ff; // Position inside the current bit cell.
  logic [2:0] bit_ff; // Bit index inside the byte.
  logic [31:0] spin_ff; // Spin-up wait counter.
  logic desel_q_ff; // Select was high in the previous cycle.
  logic irq_ff, xreq_ff, motor_ff, seen_ff, rdq_ff, prev_bit_ff;
  logic stepped_ff, wpulse_ff;
  logic sg_busy, sg_done;

  // ============================================================
  // Host access decode: one access per falling select edge.
  wire soft_clr = !master_reset_n;
  wire take = !cs_n && desel_q_ff;
  wire wr_take = take && !rw;
  wire rd_take = take && rw;
  wire busy = (state_ff != st_idle);
  wire [3:0] op = host_data_lines_i[7:4];
  wire wr_cmd = wr_take && at_idx(reg_index_bits, `FDCP_IDX_STATUS);
  wire force_cmd = wr_cmd && (op == `FDCP_OP_FORCE);
  wire rd_status = rd_take && at_idx(reg_index_bits, `FDCP_IDX_STATUS);
  wire wr_data = wr_take && at_idx(reg_index_bits, `FDCP_IDX_DATA);
  wire rd_data = rd_take && at_idx(reg_index_bits, `FDCP_IDX_DATA);
  wire [7:0] status_w = {motor_ff, 4'h0, (track_ff == 8'h00),
                         xreq_ff, busy};

  wire [7:0] rd_mux =
    at_idx(reg_index_bits, `FDCP_IDX_STATUS) ? status_w :
    at_idx(reg_index_bits, `FDCP_IDX_TRACK) ? track_ff :
    at_idx(reg_index_bits, `FDCP_IDX_SECTOR) ? sector_ff : data_ff;

  assign host_data_lines_oe = !cs_n && rw;
  assign host_data_lines_o = dout_ff;
  assign command_done_irq = irq_ff;
  assign byte_transfer_request = xreq_ff;
  assign spindle_drive_enable = motor_ff;
  assign write_pulse = wpulse_ff;

  // ============================================================
  // Stepping: target and direction per command.
  wire [3:0] cop = cmd_ff[7:4];
  wire single = (cop == `FDCP_OP_STEP_IN) || (cop == `FDCP_OP_STEP_OUT);
  wire [7:0] target = (cop == `FDCP_OP_RESTORE) ? 8'h00 : data_ff;
  wire need_move = single ? !stepped_ff : (target != track_ff);
  wire step_dir = single ? !cmd_ff[5] : (target > track_ff);
  wire sg_start = (state_ff == st_step) && !sg_busy && need_move;

  fdcp_step_gen #(.STEP_RATE_CYC(STEP_RATE_CYC)) u_step (
    .clk(clk),
    .rst_n(rst_n),
    .clr(soft_clr || force_cmd),
    .start(sg_start),
    .dir_in(step_dir),
    .busy(sg_busy),
    .done(sg_done),
    .step_pulse(step_pulse),
    .head_direction(head_direction)
  );

  // ============================================================
  // Bit cell timing shared by read recovery and write shifting.
  // low level means MFM
  wire [15:0] cell_len = !density_select_n ? 16'(`FDCP_MFM_CELL_CYC) :
                                             16'(`FDCP_FM_CELL_CYC);
  wire [15:0] half = {1'b0, cell_len[15:1]};
  wire [15:0] quart = {2'b00, cell_len[15:2]};
  wire rd_edge = rdq_ff && !raw_read_n;
  wire in_mid = (cell_ff >= quart) && (cell_ff < half + quart);
  wire rx_bnd = (cell_ff == cell_len - 16'h0001) ||
                (rd_edge && !in_mid && (cell_ff >= quart));
  wire streaming = (state_ff == st_rx) || (state_ff == st_tx);
  wire byte_end = streaming && rx_bnd && (bit_ff == 3'h7);
  wire [7:0] rx_byte = {shift_ff[6:0], seen_ff};
  wire last_byte = byte_end && (bytes_ff == 8'(`FDCP_SECT_BYTES - 1));
  wire spun = motor_ff && (spin_ff == 32'(SPINUP_CYC - 1));
  wire step_fin = (state_ff == st_step) && !sg_busy && !need_move;
  wire finish = step_fin || last_byte || (force_cmd && busy);

  wire [15:0] pre = 16'(`FDCP_PRECOMP_CYC);
  wire [15:0] dpos = !cmd_ff[`FDCP_CMD_PRECOMP_BIT] ? half :
                     prev_bit_ff ? half + pre : half - pre;

  // ============================================================
  // Sequencer next state.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      st_idle: begin
        if (wr_cmd && !force_cmd) begin
          if (host_data_lines_i[`FDCP_CMD_MOTOR_BIT] && !motor_ff) begin
            nxt_state = st_spin;
          end else if (op == `FDCP_OP_READ) begin
            nxt_state = st_rx;
          end else if (op == `FDCP_OP_WRITE) begin
            nxt_state = st_tx;
          end else begin
            nxt_state = st_step;
          end
        end
      end
      st_spin: begin
        if (spin_ff == 32'(SPINUP_CYC - 1)) begin
          nxt_state = (cop == `FDCP_OP_READ) ? st_rx :
                      (cop == `FDCP_OP_WRITE) ? st_tx : st_step;
        end
      end
      default: begin
        nxt_state = state_ff;
      end
    endcase
    if (finish) begin
      nxt_state = st_idle;
    end
  end

  // Sequencer, command latch and motor control.
  // master reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= st_idle;
      cmd_ff <= `FDCP_RST_BYTE;
      motor_ff <= 1'b0;
      spin_ff <= 32'h0000_0000;
    end else if (soft_clr) begin
      state_ff <= st_idle;
      cmd_ff <= `FDCP_RST_BYTE;
      motor_ff <= 1'b0;
      spin_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      // A busy port refuses every command except force interrupt.
      if (wr_cmd && !busy && !force_cmd) begin
        cmd_ff <= host_data_lines_i;
        motor_ff <= motor_ff || host_data_lines_i[`FDCP_CMD_MOTOR_BIT];
      end
      spin_ff <= (state_ff == st_spin && !spun) ?
                 spin_ff + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // Host-visible registers.  The set of a flag wins over its clear.
  // register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      track_ff <= `FDCP_RST_BYTE;
      sector_ff <= `FDCP_RST_BYTE;
      data_ff <= `FDCP_RST_BYTE;
      dout_ff <= `FDCP_RST_BYTE;
      irq_ff <= 1'b0;
      xreq_ff <= 1'b0;
      stepped_ff <= 1'b0;
      desel_q_ff <= 1'b1;
    end else if (soft_clr) begin
      track_ff <= `FDCP_RST_BYTE;
      sector_ff <= `FDCP_RST_BYTE;
      data_ff <= `FDCP_RST_BYTE;
      dout_ff <= `FDCP_RST_BYTE;
      irq_ff <= 1'b0;
      xreq_ff <= 1'b0;
      stepped_ff <= 1'b0;
      desel_q_ff <= 1'b1;
    end else begin
      desel_q_ff <= cs_n;
      dout_ff <= rd_mux;
      if (wr_take && at_idx(reg_index_bits, `FDCP_IDX_TRACK) && !busy) begin
        track_ff <= host_data_lines_i;
      end else if (sg_done) begin
        track_ff <= head_direction ? track_ff + 8'h01 : track_ff - 8'h01;
      end
      if (wr_take && at_idx(reg_index_bits, `FDCP_IDX_SECTOR) && !busy) begin
        sector_ff <= host_data_lines_i;
      end
      if (byte_end && state_ff == st_rx) begin
        data_ff <= rx_byte;
      end else if (wr_data) begin
        data_ff <= host_data_lines_i;
      end
      stepped_ff <= (state_ff == st_step) && (stepped_ff || sg_done);
      irq_ff <= finish || (irq_ff && !rd_status && !wr_cmd);
      // full on read, empty on write
      xreq_ff <= byte_end || (nxt_state == st_tx && state_ff != st_tx) ||
                 (xreq_ff && !rd_data && !wr_data && !finish);
    end
  end

  // Raw read recovery and serial write shifting on one cell clock.
  // cell window recovery
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cell_ff <= 16'h0000;
      bit_ff <= 3'h0;
      bytes_ff <= 8'h00;
      shift_ff <= 8'h00;
      seen_ff <= 1'b0;
      rdq_ff <= 1'b1;
      prev_bit_ff <= 1'b0;
      wpulse_ff <= 1'b0;
    end else if (soft_clr || !streaming) begin
      cell_ff <= 16'h0000;
      bit_ff <= 3'h0;
      bytes_ff <= 8'h00;
      shift_ff <= data_ff;
      seen_ff <= 1'b0;
      rdq_ff <= 1'b1;
      prev_bit_ff <= 1'b0;
      wpulse_ff <= 1'b0;
    end else begin
      rdq_ff <= raw_read_n;
      cell_ff <= rx_bnd ? 16'h0000 : cell_ff + 16'h0001;
      seen_ff <= rx_bnd ? 1'b0 : (seen_ff || (rd_edge && in_mid));
      // clock pulse then shifted data pulse
      wpulse_ff <= (state_ff == st_tx) && ((cell_ff == 16'h0000) ||
                   (cell_ff == dpos && shift_ff[7]));
      if (rx_bnd) begin
        bit_ff <= bit_ff + 3'h1;
        prev_bit_ff <= shift_ff[7];
        if (state_ff == st_rx) begin
          shift_ff <= rx_byte;
        end else begin
          shift_ff <= byte_end ? data_ff : {shift_ff[6:0], 1'b0};
        end
        if (byte_end) begin
          bytes_ff <= bytes_ff + 8'h01;
        end
      end
    end
  end

  // ============================================================
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  bus_release_a: assert property (
    cs_n |-> !host_data_lines_oe)
    else $error("bus driven while deselected");
  status_clear_a: assert property (
    rd_status && !finish |=> !command_done_irq)
    else $error("interrupt not cleared by status read");
  track_step_a: assert property (
    sg_done && busy && master_reset_n |=>
      track_ff == $past(track_ff) + ($past(head_direction) ? 8'h01 : 8'hFF))
    else $error("track count did not follow the step");
  busy_hold_a: assert property (
    wr_take && at_idx(reg_index_bits, `FDCP_IDX_SECTOR) && busy
      && master_reset_n |=> $stable(sector_ff))
    else $error("sector loaded while busy");
  sector_wr_a: assert property (
    wr_take && at_idx(reg_index_bits, `FDCP_IDX_SECTOR) && !busy
      && master_reset_n |=> sector_ff == $past(host_data_lines_i))
    else $error("sector write lost");
  xreq_clear_a: assert property (
    wr_data && !byte_end && state_ff != st_idle && master_reset_n
      |=> !byte_transfer_request)
    else $error("transfer request not cleared by data write");
  mreset_a: assert property (
    !master_reset_n |=> state_ff == st_idle && !command_done_irq
      && !byte_transfer_request)
    else $error("master reset did not clear the port");
  motor_a: assert property (
    state_ff == st_spin |-> spindle_drive_enable ##1 spindle_drive_enable)
    else $error("motor off during spin-up");
  desel_a: assert property (
    cs_n && master_reset_n && !busy |=> $stable(sector_ff))
    else $error("register changed while deselected");

  seek_done_c: cover property (step_fin ##1 command_done_irq);
  rx_byte_c: cover property (state_ff == st_rx && byte_end);
  tx_pulse_c: cover property (state_ff == st_tx && write_pulse);
  force_c: cover property (force_cmd && busy);

endmodule

// ==== bench/fdcp_drive_model.sv ====
`timescale 1ns/1ps

// ============================================================
// Drive model: follows the head, counts steps, times write pulses.
module fdcp_drive_model (
  // Clock, reset and statistics clear.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  // Media pattern: read pulse period, zero for a blank track.
  input wire logic [15:0] read_gap,
  // Controller outputs that reach the drive.
  input wire logic step_pulse,
  input wire logic head_direction,
  input wire logic spindle_drive_enable,
  input wire logic write_pulse,
  // Raw read line back to the controller.
  output logic raw_read_n,
  // Observations for the bench.
  output logic [7:0] head_pos,
  output logic [7:0] step_cnt,
  output logic last_dir,
  output logic motor_late,
  output logic [15:0] gap_min,
  output logic [15:0] gap_max,
  output logic [15:0] wp_cnt
);
  logic step_q; // Step level one cycle ago.
  logic [15:0] since; // Cycles since the last write pulse.
  logic [15:0] rd_cnt; // Position inside the current read period.

  // One low read pulse in the middle of each period.
  // The line rests high while no period is set.
  // raw read pulses
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_cnt <= 16'h0000;
      raw_read_n <= 1'b1;
    end else if (read_gap == 16'h0000) begin
      rd_cnt <= 16'h0000;
      raw_read_n <= 1'b1;
    end else begin
      rd_cnt <= (rd_cnt == read_gap - 16'h0001) ? 16'h0000 :
                rd_cnt + 16'h0001;
      raw_read_n <= (rd_cnt != {1'b0, read_gap[15:1]});
    end
  end

  // Each rising step edge moves the head by one track.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= 1'b0;
      head_pos <= 8'h00;
      step_cnt <= 8'h00;
      last_dir <= 1'b0;
      motor_late <= 1'b0;
    end else begin
      step_q <= step_pulse;
      if (step_pulse && !step_q) begin
        step_cnt <= step_cnt + 8'h01;
        last_dir <= head_direction;
        head_pos <= head_direction ? head_pos + 8'h01 : head_pos - 8'h01;
        motor_late <= motor_late | !spindle_drive_enable;
      end
    end
  end

  // Gap statistics; the first pulse after a clear only starts timing.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n || clear) begin
      since <= 16'h0000;
      gap_min <= 16'hFFFF;
      gap_max <= 16'h0000;
      wp_cnt <= 16'h0000;
    end else begin
      since <= write_pulse ? 16'h0001 : since + 16'h0001;
      if (write_pulse) begin
        wp_cnt <= wp_cnt + 16'h0001;
        if (wp_cnt != 16'h0000 && since < gap_min) gap_min <= since;
        if (wp_cnt != 16'h0000 && since > gap_max) gap_max <= since;
      end
    end
  end
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps

// ============================================================
// Self-checking bench: host register cycles against a drive model.
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mrst_n = 1'b1;
  logic cs_n = 1'b1;
  logic rw = 1'b0;
  logic [1:0] idx = 2'h0;
  logic [7:0] din = 8'h00;
  logic dsel_n = 1'b1;
  logic clr = 1'b0;
  logic [15:0] rgap = 16'h0000;
  logic [7:0] dout, head_pos, step_cnt;
  logic oe, irq, xreq, raw_n, stp, hdir, spin, wpul, last_dir, late;
  logic [15:0] gmin, gmax, wcnt;
  int n_checks = 0;
  int bad_count = 0;
  int cyc = 0;
  int t0;
  logic [7:0] cmds [3] = '{8'h50, 8'h70, 8'h00};
  logic [7:0] trks [3] = '{8'h05, 8'h04, 8'h00};
  logic [7:0] sts [3] = '{8'h80, 8'h80, 8'h84};
  logic dirs [3] = '{1'b1, 1'b0, 1'b0};

  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // Short step and spin-up counts keep the run brief.
  fdcp_port #(.STEP_RATE_CYC(300), .SPINUP_CYC(20)) DUT (
    .clk(clk), .rst_n(rst_n), .master_reset_n(mrst_n),
    .cs_n(cs_n), .rw(rw), .reg_index_bits(idx),
    .host_data_lines_i(din), .host_data_lines_o(dout),
    .host_data_lines_oe(oe), .command_done_irq(irq),
    .byte_transfer_request(xreq), .raw_read_n(raw_n),
    .density_select_n(dsel_n), .step_pulse(stp),
    .head_direction(hdir), .spindle_drive_enable(spin),
    .write_pulse(wpul));

  fdcp_drive_model drive (
    .clk(clk), .rst_n(rst_n), .clear(clr), .read_gap(rgap),
    .step_pulse(stp),
    .head_direction(hdir), .spindle_drive_enable(spin),
    .write_pulse(wpul), .raw_read_n(raw_n), .head_pos(head_pos),
    .step_cnt(step_cnt), .last_dir(last_dir), .motor_late(late),
    .gap_min(gmin), .gap_max(gmax), .wp_cnt(wcnt));

  // ============================================================
  // Shared tasks.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One write cycle; select drops for exactly one taking edge.
  task automatic wr(input logic [1:0] i, input logic [7:0] d);
    @(negedge clk);
    cs_n = 1'b0;
    rw = 1'b0;
    idx = i;
    din = d;
    @(negedge clk);
    cs_n = 1'b1;
  endtask

  // One read cycle; data is taken one edge after the index settles.
  task automatic rc(input logic [1:0] i, input logic [7:0] exp);
    @(negedge clk);
    cs_n = 1'b0;
    rw = 1'b1;
    idx = i;
    @(negedge clk);
    chk(oe, 1'b1);
    chk(dout, exp);
    cs_n = 1'b1;
    rw = 1'b0;
  endtask

  // Bounded wait for the completion (0) or transfer request (1) flag.
  task automatic wait_on(input bit use_req, input int lim);
    int k;
    k = 0;
    while ((use_req ? xreq : irq) !== 1'b1 && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk(k < lim, 1'b1);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ============================================================
  // Test sequence.
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    chk(oe, 1'b0);
    rc(2'h0, 8'h04);
    rc(2'h1, 8'h00);
    rc(2'h2, 8'h00);
    rc(2'h3, 8'h00);
    $display("test reset done");
    wr(2'h1, 8'h03);
    wr(2'h2, 8'hA5);
    wr(2'h3, 8'h5A);
    rc(2'h1, 8'h03);
    rc(2'h2, 8'hA5);
    rc(2'h3, 8'h5A);
    // Bus activity while deselected must leave everything alone.
    @(negedge clk);
    rw = 1'b1;
    idx = 2'h2;
    @(negedge clk);
    chk(oe, 1'b0);
    rw = 1'b0;
    din = 8'hFF;
    repeat (3) @(negedge clk);
    rc(2'h2, 8'hA5);
    @(negedge clk) mrst_n = 1'b0;
    @(negedge clk) mrst_n = 1'b1;
    rc(2'h2, 8'h00);
    rc(2'h1, 8'h00);
    $display("test registers done");
    // Seek with motor on; a track load while busy is refused.
    wr(2'h3, 8'h04);
    wr(2'h0, 8'h18);
    wr(2'h1, 8'h77);
    wait_on(1'b0, 2000);
    chk(spin, 1'b1);
    rc(2'h0, 8'h80);
    @(negedge clk);
    chk(irq, 1'b0);
    rc(2'h1, 8'h04);
    chk(head_pos, 8'h04);
    $display("test seek done");
    for (int i = 0; i < 3; i++) begin
      wr(2'h0, cmds[i]);
      wait_on(1'b0, 2000);
      rc(2'h0, sts[i]);
      rc(2'h1, trks[i]);
      chk(last_dir, dirs[i]);
      chk(head_pos, trks[i]);
    end
    chk(step_cnt, 8'h0A);
    chk(late, 1'b0);
    $display("test stepping done");
    // Byte period of the read path in each density.
    for (int d = 0; d < 2; d++) begin
      dsel_n = d[0];
      wr(2'h0, 8'h80);
      // One media pulse in the middle of every cell reads as all ones.
      rgap = d ? 16'h0190 : 16'h00C8;
      wait_on(1'b1, 4000);
      t0 = cyc;
      rc(2'h3, 8'hFF);
      @(negedge clk);
      chk(xreq, 1'b0);
      wait_on(1'b1, 4000);
      chk(16'(cyc - t0), d ? 16'h0C80 : 16'h0640);
      rc(2'h3, 8'hFF);
      wr(2'h0, 8'hD0);
      rgap = 16'h0000;
      wait_on(1'b0, 10);
      rc(2'h0, 8'h84);
    end
    $display("test read done");
    // Write pulse spacing, plain and precompensated.
    dsel_n = 1'b0;
    for (int p = 0; p < 2; p++) begin
      wr(2'h3, p ? 8'hFF : 8'h00);
      wr(2'h0, p ? 8'hA2 : 8'hA0);
      wait_on(1'b1, 5);
      // Refilling the data register answers the request.
      wr(2'h3, p ? 8'hFF : 8'h00);
      chk(xreq, 1'b0);
      repeat (300) @(negedge clk);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      repeat (1000) @(negedge clk);
      chk(gmin, p ? 16'h005E : 16'h00C8);
      chk(gmax, p ? 16'h006A : 16'h00C8);
      wr(2'h0, 8'hD0);
      wait_on(1'b0, 10);
    end
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (500) @(negedge clk);
    chk(wcnt, 16'h0000);
    $display("test write done");
    end_sim();
  end

  // Watchdog: the sequence needs roughly 16k cycles.
  initial begin
    #1000000;
    bad_count++;
    end_sim();
  end
endmodule
